// [bench/watchdog_with_soft_reset_tb_top.sv]
// self-checking bench of the watchdog with soft reset
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
  $display("mismatch %0t: got %h want %h", $time, a, b); end end
module watchdog_with_soft_reset_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // ====================
  // stimulus and observation
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       chipReset;
  logic       powerDown = 1'b0;
  logic       idleMode = 1'b0;
  logic [3:0] sysPrescale = 4'h0;
  logic [7:0] sfrAddr = 8'h00;
  logic       sfrWrEn = 1'b0;
  logic [7:0] sfrWrData = 8'h00;
  logic       sfrRdEn = 1'b0;
  wire  [7:0] sfrRdData;
  wire        wdtResetOut;
  wire        running;
  int         errors = 0;
  int         checked = 0;
  int         cycles = 0;
  int         n;
  logic [7:0] d;
  always #4 clk = ~clk;
  // hang guard sized for about 76k cycles of tests
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      errors++;
      end_sim();
    end
  end
  wdtsr_top dut (.clk(clk), .rst(rst), .chipReset(chipReset), .powerDown(powerDown),
    .idleMode(idleMode), .sysPrescale(sysPrescale), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn),
    .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData),
    .wdtResetOut(wdtResetOut), .running(running));
  wdtsr_cpu_model u_cpu (.clk(clk), .rst(rst), .resetReq(wdtResetOut), .chipReset(chipReset));
  // ====================
  // bus tasks and expectations
  function automatic int period(input int ps, input int system_timer_prescale);
    return (system_timer_prescale + 1) << (ps + 14);
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    sfrAddr <= a;
    sfrWrData <= v;
    sfrWrEn <= 1'b1;
    @(posedge clk);
    sfrWrEn <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    sfrAddr <= a;
    sfrRdEn <= 1'b1;
    @(posedge clk);
    sfrRdEn <= 1'b0;
    @(negedge clk);
    `CHK(sfrRdData, e)
  endtask
  // reads between the two bytes are legal, writes are not
  task automatic feed(input logic [7:0] c);
    wr(8'ha6, 8'h1e);
    rd(8'ha7, c);
    wr(8'ha6, 8'he1);
  endtask
  task automatic expire(input int want);
    for (n = 0; n < 70000 && wdtResetOut !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    `CHK(n, want)
  endtask
  task automatic waitRst();
    @(posedge clk);
    #1;
    `CHK(wdtResetOut, 1'b1)
    for (n = 0; n < 20 && (wdtResetOut || chipReset); n++) begin
      @(posedge clk);
      #1;
    end
    `CHK(wdtResetOut || chipReset, 1'b0)
  endtask
  task automatic done(input string s);
    $display("test %s ended, checked %0d errors %0d", s, checked, errors);
  endtask
  task automatic end_sim();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ====================
  // main sequence
  initial begin
    void'($urandom(71456));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(8'ha7, 8'h00);
    rd(8'ha6, 8'h00);
    rd(8'($urandom) & 8'h7f, 8'h00);
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom) & 8'hf9;
      wr(8'ha7, d);
      rd(8'ha7, d & 8'hf0);
    end
    done("registers");
    wr(8'ha7, 8'h00);
    feed(8'h00);
    rd(8'ha7, 8'h01);
    repeat (10000) @(posedge clk);
    feed(8'h01);
    expire(period(0, 0));
    waitRst();
    rd(8'ha7, 8'h02);
    @(posedge clk) sysPrescale <= 4'h1;
    wr(8'ha7, 8'h00);
    feed(8'h00);
    expire(period(0, 1));
    waitRst();
    @(posedge clk) sysPrescale <= 4'h0;
    done("timeout");
    wr(8'ha7, 8'h10);
    feed(8'h10);
    @(posedge clk) idleMode <= 1'b1;
    repeat (17000) @(posedge clk);
    idleMode <= 1'b0;
    rd(8'ha7, 8'h11);
    @(posedge clk) powerDown <= 1'b1;
    @(posedge clk) powerDown <= 1'b0;
    rd(8'ha7, 8'h10);
    done("idle");
    wr(8'ha6, 8'h5a);
    wr(8'ha6, 8'ha5);
    waitRst();
    rd(8'ha7, 8'h04);
    // wrong first byte, wrong second byte, foreign write mid-pair
    for (int k = 0; k < 3; k++) begin
      wr(8'ha7, 8'h00);
      d = 8'($urandom) & 8'hf0;
      if (k > 0) wr(8'ha6, 8'h1e);
      wr(k == 2 ? 8'ha7 : 8'ha6, d);
      waitRst();
      rd(8'ha7, 8'h06);
    end
    done("sequences");
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    rd(8'ha7, 8'h00);
    done("reset");
    end_sim();
  end
endmodule // watchdog_with_soft_reset_tb_top

// [bench/wdtsr_cpu_model.sv]
// cpu reset logic model: turns the watchdog request into a chip reset
module wdtsr_cpu_model #(
  parameter int HOLD = 2
) (
  // clock and reset
  input  logic clk,
  input  logic rst,
  // request in, chip reset out
  input  logic resetReq,
  output logic chipReset
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] hold_q;
  // stretch the reset so the chip stays down a little past the pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      hold_q <= 4'h0;
    end else if (resetReq) begin
      hold_q <= 4'(HOLD);
    end else if (hold_q != 4'h0) begin
      hold_q <= hold_q - 4'h1;
    end
  end
  assign chipReset = resetReq || hold_q != 4'h0;
endmodule // wdtsr_cpu_model

// [bench/wdtsr_props.sv]
// concurrent checks on the watchdog top ports
module wdtsr_props (
  // clock and resets
  input logic       clk,
  input logic       rst,
  input logic       chipReset,
  // power and prescale
  input logic       powerDown,
  input logic       idleMode,
  input logic [3:0] sysPrescale,
  // register port
  input logic [7:0] sfrAddr,
  input logic       sfrWrEn,
  input logic [7:0] sfrWrData,
  input logic       sfrRdEn,
  input logic [7:0] sfrRdData,
  // outputs
  input logic       wdtResetOut,
  input logic       running
);
  timeunit 1ns;
  timeprecision 100ps;
  // ====================
  // command pair tracking
  logic       pend_q;
  logic [7:0] first_q;
  logic       cmdWr;
  logic       badWr;
  assign cmdWr = sfrWrEn && sfrAddr == 8'ha6;
  // mid-pair, anything but the matching second byte is bad
  assign badWr = sfrWrEn && (pend_q ?
    !(cmdWr && sfrWrData == (first_q == 8'h1e ? 8'he1 : 8'ha5)) :
    cmdWr && sfrWrData != 8'h1e && sfrWrData != 8'h5a);
  always_ff @(posedge clk) begin
    if (rst || chipReset) begin
      pend_q <= 1'b0;
    end else if (sfrWrEn) begin
      pend_q <= !pend_q && cmdWr && !badWr;
      first_q <= sfrWrData;
    end
  end
  // ====================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence pulse4;
    wdtResetOut [*4] ##1 !wdtResetOut;
  endsequence
  sequence feedPair;
    cmdWr && pend_q && first_q == 8'h1e && sfrWrData == 8'he1;
  endsequence
  sequence softPair;
    cmdWr && pend_q && first_q == 8'h5a && sfrWrData == 8'ha5;
  endsequence
  a_bad_resets: assert property (badWr |=> pulse4)
    else $error("bad pair gave no reset pulse");
  a_soft_resets: assert property (softPair |=> pulse4)
    else $error("soft reset pair gave no pulse");
  a_feed_runs: assert property (feedPair ##0 !powerDown |=> running)
    else $error("feed did not start the watchdog");
  a_pd_stops: assert property (powerDown |=> !running)
    else $error("running during power-down");
  a_chip_stops: assert property (chipReset |=> !running)
    else $error("running after chip reset");
  a_rst_clears: assert property ($fell(rst) |->
    !running && !wdtResetOut && sfrRdData == 8'h00)
    else $error("outputs not clear after reset");
  a_fire_stops: assert property ($rose(wdtResetOut) |-> ##[0:1] !running)
    else $error("still running after firing");
  a_cmd_rdzero: assert property (sfrRdEn && sfrAddr == 8'ha6 |=> sfrRdData == 8'h00)
    else $error("command register read nonzero");
  a_ctrl_rd: assert property (sfrRdEn && sfrAddr == 8'ha7 |=>
    sfrRdData[3] == 1'b0 && sfrRdData[0] == $past(running))
    else $error("control read bits 3 or 0 wrong");
endmodule // wdtsr_props

bind wdtsr_top wdtsr_props u_props (.clk(clk), .rst(rst), .chipReset(chipReset),
  .powerDown(powerDown), .idleMode(idleMode), .sysPrescale(sysPrescale),
  .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn),
  .sfrRdData(sfrRdData), .wdtResetOut(wdtResetOut), .running(running));

// [inc/wdtsr_map.vh]
// register map, command bytes and constants of the watchdog with soft reset
`ifndef WDTSR_MAP_VH
`define WDTSR_MAP_VH

// ==========================================================
// special function register addresses
`define WDTSR_ADDR_CMD      8'ha6
`define WDTSR_ADDR_CTRL     8'ha7

// ==========================================================
// control register fields
`define WDTSR_PS_HI         7
`define WDTSR_PS_LO         5
`define WDTSR_IDLE_BIT      4
`define WDTSR_SOFT_RESET_FLAG_BIT     2
`define WDTSR_OVF_BIT       1
`define WDTSR_RUN_BIT       0
`define WDTSR_CTRL_RESET    8'h00

// ==========================================================
// command sequence bytes
`define WDTSR_FEED_FIRST    8'h1e
`define WDTSR_FEED_SECOND   8'he1
`define WDTSR_SOFT_RESET_FLAG_FIRST   8'h5a
`define WDTSR_SOFT_RESET_FLAG_SECOND  8'ha5

// ==========================================================
// counter geometry and timing
`define WDTSR_CNT_W         14
`define WDTSR_PRE_W         7
`define WDTSR_TPS_W         4
`define WDTSR_RST_PULSE     4'h4

`endif

// [src/wdtsr_prescaler.v]
// system timer divider and 7-bit programmable watchdog prescaler
`include "wdtsr_map.vh"

module wdtsr_prescaler #(
  parameter PRE_W = `WDTSR_PRE_W,
  parameter TPS_W = `WDTSR_TPS_W
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst,
  // control
  input  wire             clear,
  input  wire             run,
  input  wire [2:0]       periodSel,
  input  wire [TPS_W-1:0] sysPrescale,
  // enable out to the main counter
  output wire             tick
);

  reg  [TPS_W-1:0] tpsCnt_q;
  reg  [PRE_W-1:0] preCnt_q;
  wire [7:0]       maskWide;
  wire [PRE_W-1:0] preMask;
  wire             tpsTick;
  wire             preTerm;

  // ==========================================================
  // divide-by-(prescale+1); zero prescale gives one step per cycle
  assign tpsTick = run && (tpsCnt_q == sysPrescale);

  // prescaler divides by 2 to the period code
  assign maskWide = (8'h01 << periodSel) - 8'h01;
  assign preMask  = maskWide[PRE_W-1:0];
  assign preTerm  = ((preCnt_q | ~preMask) == {PRE_W{1'b1}});
  assign tick     = tpsTick && preTerm;

  // both stages restart from zero on clear so a feed buys a full period
  always @(posedge clk) begin
    if (rst || clear) begin
      tpsCnt_q <= {TPS_W{1'b0}};
      preCnt_q <= {PRE_W{1'b0}};
    end else if (run) begin
      if (tpsTick) begin
        tpsCnt_q <= {TPS_W{1'b0}};
        preCnt_q <= preTerm ? {PRE_W{1'b0}} : preCnt_q + {{(PRE_W-1){1'b0}}, 1'b1};
      end else begin
        tpsCnt_q <= tpsCnt_q + {{(TPS_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // wdtsr_prescaler

// [src/wdtsr_top.v]
// watchdog timer with software reset: register port, sequences, counter
`include "wdtsr_map.vh"

module wdtsr_top #(
  parameter CNT_W    = `WDTSR_CNT_W,
  parameter PRE_W    = `WDTSR_PRE_W,
  parameter TPS_W    = `WDTSR_TPS_W,
  parameter PULSE_W  = 4,
  parameter [PULSE_W-1:0] RST_PULSE = `WDTSR_RST_PULSE
) (
  // clock and power-on reset
  input  wire             clk,
  input  wire             rst,
  // chip-wide reset, keeps the cause flags
  input  wire             chipReset,
  // power state and system timer prescale
  input  wire             powerDown,
  input  wire             idleMode,
  input  wire [TPS_W-1:0] sysPrescale,
  // special function register port
  input  wire [7:0]       sfrAddr,
  input  wire             sfrWrEn,
  input  wire [7:0]       sfrWrData,
  input  wire             sfrRdEn,
  output reg  [7:0]       sfrRdData,
  // reset request to the cpu reset logic, and running status
  output wire             wdtResetOut,
  output wire             running
);

  // ==========================================================
  // sequence states
  localparam [1:0] SEQ_IDLE  = 2'b00;
  localparam [1:0] SEQ_FEED  = 2'b01;
  localparam [1:0] SEQ_SOFT_RESET_FLAG = 2'b10;

  reg  [1:0]         seqState_q;
  reg  [1:0]         seqState_d;
  reg  [2:0]         periodSel_q;
  reg                idleFreeze_q;
  reg                softFlag_q;
  reg                ovfFlag_q;
  reg                running_q;
  reg  [CNT_W-1:0]   count_q;
  reg  [PULSE_W-1:0] pulseCnt_q;
  reg                goodFeed;
  reg                goodSwrst;
  reg                badSeq;
  wire               cmdWrite;
  wire               ctrlWrite;
  wire               otherWrite;
  wire               countEn;
  wire               tick;
  wire               overflow;
  wire               fireReset;
  wire               clearCount;
  wire [7:0]         ctrlValue;
  wire [7:0]         ctrlResetVal;

  // ==========================================================
  // address decode
  // reset image of the control register, sliced per field so widths match
  assign ctrlResetVal = `WDTSR_CTRL_RESET;

  assign cmdWrite   = sfrWrEn && (sfrAddr == `WDTSR_ADDR_CMD);
  assign ctrlWrite  = sfrWrEn && (sfrAddr == `WDTSR_ADDR_CTRL);
  assign otherWrite = sfrWrEn && !cmdWrite;

  // ==========================================================
  // command sequence decoder
  // reads never disturb a half-done sequence; a write anywhere else
  // between the two bytes is taken as a broken sequence
  always @* begin
    seqState_d = seqState_q;
    goodFeed   = 1'b0;
    goodSwrst  = 1'b0;
    badSeq     = 1'b0;
    case (seqState_q)
      SEQ_IDLE: begin
        if (cmdWrite) begin
          if (sfrWrData == `WDTSR_FEED_FIRST) begin
            seqState_d = SEQ_FEED;
          end else if (sfrWrData == `WDTSR_SOFT_RESET_FLAG_FIRST) begin
            seqState_d = SEQ_SOFT_RESET_FLAG;
          end else begin
            badSeq = 1'b1;
          end
        end
      end
      SEQ_FEED: begin
        if (cmdWrite) begin
          seqState_d = SEQ_IDLE;
          if (sfrWrData == `WDTSR_FEED_SECOND) begin
            goodFeed = 1'b1;
          end else begin
            badSeq = 1'b1;
          end
        end else if (otherWrite) begin
          seqState_d = SEQ_IDLE;
          badSeq     = 1'b1;
        end
      end
      SEQ_SOFT_RESET_FLAG: begin
        if (cmdWrite) begin
          seqState_d = SEQ_IDLE;
          if (sfrWrData == `WDTSR_SOFT_RESET_FLAG_SECOND) begin
            goodSwrst = 1'b1;
          end else begin
            badSeq = 1'b1;
          end
        end else if (otherWrite) begin
          seqState_d = SEQ_IDLE;
          badSeq     = 1'b1;
        end
      end
      default: begin
        seqState_d = SEQ_IDLE;
      end
    endcase
  end

  // any reset, including our own pulse, abandons a half sequence
  always @(posedge clk) begin
    if (rst || chipReset || fireReset) begin
      seqState_q <= SEQ_IDLE;
    end else begin
      seqState_q <= seqState_d;
    end
  end

  // ==========================================================
  // counting chain
  // idle freeze only holds the count; running stays set
  assign countEn    = running_q && !(idleMode && idleFreeze_q);
  assign clearCount = goodFeed || !running_q;

  wdtsr_prescaler #(
    .PRE_W       (PRE_W),
    .TPS_W       (TPS_W)
  ) u_prescaler (
    .clk         (clk),
    .rst         (rst),
    .clear       (clearCount),
    .run         (countEn),
    .periodSel   (periodSel_q),
    .sysPrescale (sysPrescale),
    .tick        (tick)
  );

  // terminal count of the 14-bit stage is the time-out
  assign overflow = tick && (count_q == {CNT_W{1'b1}});

  always @(posedge clk) begin
    if (rst || clearCount) begin
      count_q <= {CNT_W{1'b0}};
    end else if (tick) begin
      count_q <= count_q + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // ==========================================================
  // reset generation
  assign fireReset = overflow || goodSwrst || badSeq;

  // stretch the request so slow reset logic cannot miss it
  always @(posedge clk) begin
    if (rst) begin
      pulseCnt_q <= {PULSE_W{1'b0}};
    end else if (fireReset) begin
      pulseCnt_q <= RST_PULSE;
    end else if (pulseCnt_q != {PULSE_W{1'b0}}) begin
      pulseCnt_q <= pulseCnt_q - {{(PULSE_W-1){1'b0}}, 1'b1};
    end
  end

  assign wdtResetOut = (pulseCnt_q != {PULSE_W{1'b0}});

  // ==========================================================
  // running flag: set only by the enable sequence
  always @(posedge clk) begin
    if (rst || chipReset || powerDown || fireReset) begin
      running_q <= 1'b0;
    end else if (goodFeed) begin
      running_q <= 1'b1;
    end
  end

  assign running = running_q;

  // ==========================================================
  // control register: settings return to reset value on chip reset
  always @(posedge clk) begin
    if (rst || chipReset) begin
      periodSel_q  <= ctrlResetVal[`WDTSR_PS_HI:`WDTSR_PS_LO];
      idleFreeze_q <= ctrlResetVal[`WDTSR_IDLE_BIT];
    end else if (ctrlWrite) begin
      periodSel_q  <= sfrWrData[`WDTSR_PS_HI:`WDTSR_PS_LO];
      idleFreeze_q <= sfrWrData[`WDTSR_IDLE_BIT];
    end
  end

  // cause flags: only power-on clears them in hardware; a set in the
  // same cycle as a software write wins over the write
  always @(posedge clk) begin
    if (rst) begin
      softFlag_q <= 1'b0;
      ovfFlag_q  <= 1'b0;
    end else begin
      if (goodSwrst || badSeq) begin
        softFlag_q <= 1'b1;
      end else if (ctrlWrite) begin
        softFlag_q <= sfrWrData[`WDTSR_SOFT_RESET_FLAG_BIT];
      end
      if (overflow || badSeq) begin
        ovfFlag_q <= 1'b1;
      end else if (ctrlWrite) begin
        ovfFlag_q <= sfrWrData[`WDTSR_OVF_BIT];
      end
    end
  end

  // ==========================================================
  // read path: bit 3 reads zero, command address reads zero
  assign ctrlValue = {periodSel_q, idleFreeze_q, 1'b0,
                      softFlag_q, ovfFlag_q, running_q};

  always @(posedge clk) begin
    if (rst) begin
      sfrRdData <= 8'h00;
    end else if (sfrRdEn && (sfrAddr == `WDTSR_ADDR_CTRL)) begin
      sfrRdData <= ctrlValue;
    end else begin
      sfrRdData <= 8'h00;
    end
  end

endmodule // wdtsr_top
